// ===== design/fsr_regs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the floppy status/output register block only
`ifndef FSR_REGS_SVH
`define FSR_REGS_SVH

`define FSR_OFS_SRA       3'h0
`define FSR_OFS_SRB       3'h1
`define FSR_OFS_DOR       3'h2
`define FSR_OFS_TAPE      3'h3
`define FSR_OFS_MSR_RATE  3'h4
`define FSR_OFS_FIFO      3'h5
`define FSR_OFS_RSVD      3'h6
`define FSR_OFS_DIR_CCR   3'h7

`define FSR_BASE_LSB      3
`define FSR_DOR_RST       8'h00
`define FSR_BYTE_RST      8'h00
`define FSR_DOR_SEL_LO    0
`define FSR_DOR_SEL_HI    1
`define FSR_DOR_SOFT_RESET_N    2
`define FSR_DOR_DMA_PIN_ENABLE     3
`define FSR_DOR_MOT_LO    4
`define FSR_DOR_MOT_HI    7
`define FSR_SRB_FIXED     2'h3

`define FSR_CLK_PERIOD_NS 25
`define FSR_SRST_MIN_NS   100
`define FSR_SRST_CYC      ((`FSR_SRST_MIN_NS + `FSR_CLK_PERIOD_NS - 1) / `FSR_CLK_PERIOD_NS)
`define FSR_CNT_W         3

`endif

// ===== design/fsr_pkg.sv
// Types shared by the floppy status/output register block
// Assumes the constants header supplies all numbers
package fsr_pkg;

    typedef enum logic [1:0] {
        FSR_LEGACY,
        FSR_EXTENDED,
        FSR_ALTERNATE
    } fsr_mode_type;

    typedef struct packed {
        logic        aen;
        logic        ior_n;
        logic        iow_n;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } fsr_host_req_type;

    typedef struct packed {
        logic second_drive_present_n;
        logic track_zero_n;
        logic index_pulse_n;
        logic write_protect_n;
        logic read_data_n;
        logic dack_n;
        logic tc;
    } fsr_disk_in_type;

    typedef struct packed {
        logic step;
        logic step_inward;
        logic head_side_select;
        logic write_gate_out;
        logic write_data;
        logic irq;
        logic drq;
    } fsr_core_type;

endpackage

// ===== design/fsr_sync2.sv
// Two-stage synchroniser for a vector of asynchronous inputs
// Assumes each bit is a level; only the second stage is read
`timescale 1ns/1ps
module fsr_sync2 import fsr_pkg::*; #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_nxt;

    always_comb begin
        meta_nxt = d;
        q_nxt    = meta_r;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= meta_nxt;
            q      <= q_nxt;
        end
    end
endmodule

// ===== design/fsr_event_flag.sv
// Sticky flag set by a rising edge of its source, cleared on request
// Assumes the source is already in the sys_clk domain
`timescale 1ns/1ps
module fsr_event_flag import fsr_pkg::*; (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic src,
    input  wire logic clr,
    output logic      rise,
    output logic      flag_r
);
    logic prev_r;
    logic prev_nxt;
    logic flag_nxt;

    always_comb begin
        rise     = src & ~prev_r;
        prev_nxt = src;
        // Set wins over a clear in the same cycle
        flag_nxt = rise | (flag_r & ~clr);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Starts high so a source already high after reset is no edge
            prev_r <= 1'b1;
            flag_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            flag_r <= flag_nxt;
        end
    end

    chk_set_wins: assert property (@(posedge sys_clk) disable iff (rst)
        rise |=> flag_r) else $error("edge did not set flag");
endmodule

// ===== design/fsr_floppy_status_output_regs.sv
// Host register front end: status A/B, drive output control and offset decode
// Assumes ISA strobes and disk pins are asynchronous; core signals share sys_clk
`timescale 1ns/1ps
`include "fsr_regs.svh"

// Behaviour
// - Decode eight offsets; +4 and +7 split read and write; +6 reserved.
// - Legacy mode: status A/B reads leave the data bus undriven.
// - Extended status A: irq, drive2_n, step, trk0_n, head, index_n, wp_n, dir.
// - Extended status A: bit 0 one means inward, bit 3 one means side 1.
// - Alternate status A: irq, drq, latched step, active-high pins, inverted dir/head.
// - Alternate step flag latches on step active; cleared by input read or resets.
// - Extended status B mirrors motors 0/1 and write gate; bits 7,6 read one.
// - Extended status B bits 3/4 toggle on read/write data inactive edges.
// - Extended status B bit 5 reflects output control drive select bit 0.
// - Alternate status B: drive2_n, select lines low-active, three latched flags.
// - Alternate flags set on write gate rise, data inactive edges; cleared by input read.
// - Output control resets to zero on hardware reset, keeps through soft reset.
// - Output control bits 1:0 select exactly one of four drives; none during soft reset.
// - Bit 2 low holds the controller in reset until written high.
// - Soft reset lasts at least 100ns; clear-then-set writes suffice.
// - Legacy/alternate: bit 3 enables DMA and irq pins, else inputs ignored, outputs float.
// - Extended mode keeps DMA and irq pins enabled, even during soft reset.
// - Output control bits 4..7 drive motor-on outputs 0..3, one means active.
// - Configuration mode blocks host access to status A and B.
module fsr_floppy_status_output_regs import fsr_pkg::*; (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire fsr_mode_type     mode,
    input  wire logic             config_mode,
    input  wire logic [15:0]      base_addr,
    input  wire fsr_host_req_type host_req,
    output logic      [7:0]       host_data_out,
    output logic                  host_data_oe,
    input  wire fsr_disk_in_type  disk_in,
    input  wire fsr_core_type     core_in,
    input  wire logic [7:0]       main_status_in,
    input  wire logic [7:0]       fifo_read_data,
    input  wire logic [7:0]       disk_input_in,
    output logic      [3:0]       drive_select,
    output logic      [3:0]       motor_on,
    output logic                  soft_reset_n,
    output logic                  dma_pin_enable,
    output logic                  disk_irq_out,
    output logic                  disk_irq_oe,
    output logic                  drq_out,
    output logic                  drq_oe,
    output logic                  dack_active,
    output logic                  tc_active,
    output logic      [7:0]       rate_select,
    output logic      [7:0]       config_control,
    output logic                  fifo_wr_stb,
    output logic      [7:0]       fifo_wr_data,
    output logic                  fifo_rd_stb
);
    localparam logic [`FSR_CNT_W-1:0] SRST_CYC = `FSR_CNT_W'(`FSR_SRST_CYC);

    // Input synchronisers
    logic [$bits(fsr_host_req_type)-1:0] host_s;
    logic [$bits(fsr_disk_in_type)-1:0]  pin_s;
    fsr_host_req_type                    hq;
    fsr_disk_in_type                     pq;

    fsr_sync2 #(.W($bits(fsr_host_req_type))) u_host_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d       (host_req),
        .q       (host_s)
    );
    fsr_sync2 #(.W($bits(fsr_disk_in_type))) u_pin_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d       (disk_in),
        .q       (pin_s)
    );
    assign hq = fsr_host_req_type'(host_s);
    assign pq = fsr_disk_in_type'(pin_s);

    // Bus strobe edges and address decode
    logic       ior_prev_r;
    logic       iow_prev_r;
    logic       ior_prev_nxt;
    logic       iow_prev_nxt;
    logic       hit;
    logic       rd_start;
    logic       wr_start;
    logic [2:0] offs;
    logic       dir_rd;

    always_comb begin
        ior_prev_nxt = hq.ior_n;
        iow_prev_nxt = hq.iow_n;
        hit      = ~hq.aen && (hq.addr[15:`FSR_BASE_LSB] == base_addr[15:`FSR_BASE_LSB]);
        offs     = hq.addr[`FSR_BASE_LSB-1:0];
        rd_start = hit & ior_prev_r & ~hq.ior_n;
        wr_start = hit & iow_prev_r & ~hq.iow_n;
        dir_rd   = rd_start && (offs == `FSR_OFS_DIR_CCR);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Synchronisers reset low; a strobe must be seen high first
            ior_prev_r <= 1'b0;
            iow_prev_r <= 1'b0;
        end else begin
            ior_prev_r <= ior_prev_nxt;
            iow_prev_r <= iow_prev_nxt;
        end
    end

    // Writable registers and soft reset stretch
    logic [7:0]             dor_r;
    logic [7:0]             tape_r;
    logic [7:0]             dor_nxt;
    logic [7:0]             tape_nxt;
    logic [7:0]             rate_nxt;
    logic [7:0]             ccr_nxt;
    logic                   fifo_wr_nxt;
    logic [7:0]             fifo_data_nxt;
    logic [`FSR_CNT_W-1:0]  srst_cnt_r;
    logic [`FSR_CNT_W-1:0]  srst_cnt_nxt;
    logic                   soft_reset_n_nxt;

    always_comb begin
        dor_nxt       = dor_r;
        tape_nxt      = tape_r;
        rate_nxt      = rate_select;
        ccr_nxt       = config_control;
        fifo_wr_nxt   = 1'b0;
        fifo_data_nxt = fifo_wr_data;
        if (wr_start) begin
            unique case (offs)
                `FSR_OFS_DOR:      dor_nxt = hq.wdata;
                `FSR_OFS_TAPE:     tape_nxt = hq.wdata;
                `FSR_OFS_MSR_RATE: rate_nxt = hq.wdata;
                `FSR_OFS_FIFO: begin
                    fifo_wr_nxt   = 1'b1;
                    fifo_data_nxt = hq.wdata;
                end
                `FSR_OFS_DIR_CCR:  ccr_nxt = hq.wdata;
                default:           dor_nxt = dor_r;
            endcase
        end
        // Reset held while bit low, then stretched to the minimum width
        if (!dor_r[`FSR_DOR_SOFT_RESET_N]) begin
            srst_cnt_nxt = SRST_CYC;
        end else if (srst_cnt_r != '0) begin
            srst_cnt_nxt = srst_cnt_r - `FSR_CNT_W'(1);
        end else begin
            srst_cnt_nxt = srst_cnt_r;
        end
        soft_reset_n_nxt = dor_r[`FSR_DOR_SOFT_RESET_N] && (srst_cnt_r == '0);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dor_r          <= `FSR_DOR_RST;
            tape_r         <= `FSR_BYTE_RST;
            rate_select    <= `FSR_BYTE_RST;
            config_control <= `FSR_BYTE_RST;
            fifo_wr_stb    <= 1'b0;
            fifo_wr_data   <= `FSR_BYTE_RST;
            srst_cnt_r     <= SRST_CYC;
            soft_reset_n   <= 1'b0;
        end else begin
            dor_r          <= dor_nxt;
            tape_r         <= tape_nxt;
            rate_select    <= rate_nxt;
            config_control <= ccr_nxt;
            fifo_wr_stb    <= fifo_wr_nxt;
            fifo_wr_data   <= fifo_data_nxt;
            srst_cnt_r     <= srst_cnt_nxt;
            soft_reset_n   <= soft_reset_n_nxt;
        end
    end
    assign dma_pin_enable = dor_r[`FSR_DOR_DMA_PIN_ENABLE];

    // Latched status flags
    logic step_rise;
    logic step_ff;
    logic write_gate_out_ff;
    logic rdata_rise;
    logic rdata_ff;
    logic wdata_rise;
    logic wdata_ff;

    fsr_event_flag u_step_flag (
        .sys_clk (sys_clk),
        .rst     (rst),
        .src     (core_in.step),
        .clr     (dir_rd | ~soft_reset_n),
        .rise    (step_rise),
        .flag_r  (step_ff)
    );
    fsr_event_flag u_write_gate_out_flag (
        .sys_clk (sys_clk),
        .rst     (rst),
        .src     (core_in.write_gate_out),
        .clr     (dir_rd),
        .rise    (),
        .flag_r  (write_gate_out_ff)
    );
    fsr_event_flag u_rdata_flag (
        .sys_clk (sys_clk),
        .rst     (rst),
        .src     (pq.read_data_n),
        .clr     (dir_rd),
        .rise    (rdata_rise),
        .flag_r  (rdata_ff)
    );
    fsr_event_flag u_wdata_flag (
        .sys_clk (sys_clk),
        .rst     (rst),
        .src     (~core_in.write_data),
        .clr     (dir_rd),
        .rise    (wdata_rise),
        .flag_r  (wdata_ff)
    );

    // Data toggles for the extended view
    logic rdata_tgl_r;
    logic wdata_tgl_r;
    logic rdata_tgl_nxt;
    logic wdata_tgl_nxt;

    always_comb begin
        rdata_tgl_nxt = rdata_tgl_r ^ rdata_rise;
        wdata_tgl_nxt = wdata_tgl_r ^ wdata_rise;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_tgl_r <= 1'b0;
            wdata_tgl_r <= 1'b0;
        end else begin
            rdata_tgl_r <= rdata_tgl_nxt;
            wdata_tgl_r <= wdata_tgl_nxt;
        end
    end

    // Read path
    logic [7:0] sra_ext;
    logic [7:0] sra_alt;
    logic [7:0] srb_ext;
    logic [7:0] srb_alt;
    logic [7:0] data_nxt;
    logic       oe_nxt;
    logic       fifo_rd_nxt;
    logic [7:0] rd_val;
    logic       rd_drive;

    always_comb begin
        sra_ext = {core_in.irq, pq.second_drive_present_n, core_in.step,
                   pq.track_zero_n, core_in.head_side_select,
                   pq.index_pulse_n, pq.write_protect_n, core_in.step_inward};
        sra_alt = {core_in.irq, core_in.drq, step_ff, ~pq.track_zero_n,
                   ~core_in.head_side_select, ~pq.index_pulse_n,
                   ~pq.write_protect_n, ~core_in.step_inward};
        srb_ext = {`FSR_SRB_FIXED, dor_r[`FSR_DOR_SEL_LO], wdata_tgl_r,
                   rdata_tgl_r, core_in.write_gate_out, motor_on[1:0]};
        srb_alt = {pq.second_drive_present_n, ~drive_select[1:0],
                   wdata_ff, rdata_ff, write_gate_out_ff, ~drive_select[3:2]};
        rd_val   = `FSR_BYTE_RST;
        rd_drive = 1'b1;
        unique case (offs)
            `FSR_OFS_SRA: begin
                rd_val   = (mode == FSR_ALTERNATE) ? sra_alt : sra_ext;
                rd_drive = (mode != FSR_LEGACY) && !config_mode;
            end
            `FSR_OFS_SRB: begin
                rd_val   = (mode == FSR_ALTERNATE) ? srb_alt : srb_ext;
                rd_drive = (mode != FSR_LEGACY) && !config_mode;
            end
            `FSR_OFS_DOR:      rd_val = dor_r;
            `FSR_OFS_TAPE:     rd_val = tape_r;
            `FSR_OFS_MSR_RATE: rd_val = main_status_in;
            `FSR_OFS_FIFO:     rd_val = fifo_read_data;
            `FSR_OFS_RSVD:     rd_drive = 1'b0;
            `FSR_OFS_DIR_CCR:  rd_val = disk_input_in;
        endcase
        data_nxt    = host_data_out;
        oe_nxt      = host_data_oe & ~hq.ior_n;
        fifo_rd_nxt = rd_start && (offs == `FSR_OFS_FIFO);
        if (rd_start) begin
            data_nxt = rd_val;
            oe_nxt   = rd_drive;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            host_data_out <= `FSR_BYTE_RST;
            host_data_oe  <= 1'b0;
            fifo_rd_stb   <= 1'b0;
        end else begin
            host_data_out <= data_nxt;
            host_data_oe  <= oe_nxt;
            fifo_rd_stb   <= fifo_rd_nxt;
        end
    end

    // Drive, motor and DMA/irq pin outputs
    logic [3:0] ds_nxt;
    logic [3:0] mot_nxt;
    logic       pins_en;

    always_comb begin
        // One-hot select while the controller runs; none during reset
        ds_nxt  = soft_reset_n_nxt ?
                  (4'h1 << dor_nxt[`FSR_DOR_SEL_HI:`FSR_DOR_SEL_LO]) : 4'h0;
        mot_nxt = dor_nxt[`FSR_DOR_MOT_HI:`FSR_DOR_MOT_LO];
        pins_en = (mode == FSR_EXTENDED) || dor_r[`FSR_DOR_DMA_PIN_ENABLE];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            drive_select <= 4'h0;
            motor_on     <= 4'h0;
            disk_irq_out <= 1'b0;
            disk_irq_oe  <= 1'b0;
            drq_out      <= 1'b0;
            drq_oe       <= 1'b0;
            dack_active  <= 1'b0;
            tc_active    <= 1'b0;
        end else begin
            drive_select <= ds_nxt;
            motor_on     <= mot_nxt;
            disk_irq_out <= core_in.irq;
            disk_irq_oe  <= pins_en;
            drq_out      <= core_in.drq;
            drq_oe       <= pins_en;
            dack_active  <= pins_en & ~pq.dack_n;
            tc_active    <= pins_en & pq.tc;
        end
    end

    // Checks
    sequence seq_status_read;
        rd_start && (offs == `FSR_OFS_SRA || offs == `FSR_OFS_SRB);
    endsequence
    sequence seq_reset_release;
        $rose(dor_r[`FSR_DOR_SOFT_RESET_N]);
    endsequence

    chk_legacy_float: assert property (@(posedge sys_clk) disable iff (rst)
        seq_status_read and (mode == FSR_LEGACY) |=> !host_data_oe)
        else $error("legacy status read drove the bus");
    chk_config_block: assert property (@(posedge sys_clk) disable iff (rst)
        seq_status_read and config_mode |=> !host_data_oe)
        else $error("status read in configuration mode drove the bus");
    chk_dor_write: assert property (@(posedge sys_clk) disable iff (rst)
        wr_start && (offs == `FSR_OFS_DOR) |=> dor_r == $past(hq.wdata))
        else $error("output control write lost");
    chk_one_select: assert property (@(posedge sys_clk) disable iff (rst)
        soft_reset_n |-> $onehot(drive_select))
        else $error("drive select not one-hot");
    chk_srst_width: assert property (@(posedge sys_clk) disable iff (rst)
        seq_reset_release |-> !soft_reset_n [*4])
        else $error("soft reset shorter than minimum");
    chk_motor_map: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 motor_on == $past(dor_r[`FSR_DOR_MOT_HI:`FSR_DOR_MOT_LO], 1) ||
            $past(wr_start, 1))
        else $error("motor outputs do not follow output control");
    chk_pin_enable: assert property (@(posedge sys_clk) disable iff (rst)
        (mode == FSR_EXTENDED) |=> disk_irq_oe && drq_oe)
        else $error("extended mode pins not enabled");
    chk_step_latch: assert property (@(posedge sys_clk) disable iff (rst)
        step_rise |=> step_ff ##1 (step_ff || $past(dir_rd) || !$past(soft_reset_n)))
        else $error("step flag not held");
    chk_toggle_rd: assert property (@(posedge sys_clk) disable iff (rst)
        rdata_rise |=> rdata_tgl_r != $past(rdata_tgl_r))
        else $error("read data toggle missed");
endmodule

// ===== verification/fsr_host_model.sv
// Host model: ISA programmed I/O master for the register block
// Assumes the block synchronises strobes on sys_clk
`timescale 1ns/1ps
module fsr_host_model import fsr_pkg::*; (
    input  wire logic        sys_clk,
    input  wire logic [15:0] base_addr,
    input  wire logic        host_data_oe,
    output fsr_host_req_type host_req
);
    initial host_req = {1'b0, 1'b1, 1'b1, 16'h0000, 8'h00};

    // One access; seen tells whether read data was driven
    task automatic access(input logic wr, input logic [2:0] ofs, input logic [7:0] d,
                          output logic seen);
        seen = 1'b0;
        @(posedge sys_clk);
        host_req.addr  <= {base_addr[15:3], ofs};
        host_req.wdata <= d;
        repeat (3) @(posedge sys_clk);
        host_req.iow_n <= ~wr;
        host_req.ior_n <= wr;
        for (int n = 0; n < 6 && !seen; n++) begin
            @(posedge sys_clk);
            seen = !wr && host_data_oe === 1'b1;
        end
        host_req.iow_n <= 1'b1;
        host_req.ior_n <= 1'b1;
        repeat (4) @(posedge sys_clk); // Strobe high time
        // Released lines do not keep their last value
        host_req.addr  <= ~host_req.addr;
        host_req.wdata <= ~host_req.wdata;
    endtask
endmodule

// ===== verification/fsr_floppy_status_output_regs_bench.sv
// Self-checking bench for the status and drive output register block
// Assumes the host model drives all register accesses
`timescale 1ns/1ps
module fsr_floppy_status_output_regs_bench import fsr_pkg::*;;
    logic             sys_clk = 1'b0;
    logic             rst = 1'b1;
    fsr_mode_type     mode = FSR_EXTENDED;
    logic             config_mode = 1'b0;
    logic [15:0]      base_addr = 16'h03f0;
    fsr_host_req_type host_req;
    fsr_disk_in_type  disk_in = 7'h00;
    fsr_core_type     core_in = 7'h00;
    logic [7:0]       ms_in = 8'h00, ff_in = 8'h00, di_in = 8'h00;
    logic [7:0]       host_data_out, rate_select, config_control;
    logic             host_data_oe, soft_reset_n, dma_pin_enable, disk_irq_oe, drq_oe;
    logic [3:0]       drive_select, motor_on;
    logic             irq_o, drq_o, dack_o, tc_o, fws_o, frs_o;
    logic [7:0]       fwd_o;
    int               fifo_rds = 0, fifo_wrs = 0;
    logic [7:0]       exp_q[$];
    logic             oe_q = 1'b0;
    logic [31:0]      r;
    logic [7:0]       act [4] = '{8'h1c, 8'h2d, 8'h4e, 8'h8f};
    int               fail_count = 0;
    int               checks_done = 0;

    fsr_floppy_status_output_regs dut (
        .sys_clk, .rst, .mode, .config_mode, .base_addr, .host_req,
        .host_data_out, .host_data_oe, .disk_in, .core_in,
        .main_status_in(ms_in), .fifo_read_data(ff_in), .disk_input_in(di_in),
        .drive_select, .motor_on, .soft_reset_n, .dma_pin_enable,
        .disk_irq_out(irq_o), .disk_irq_oe, .drq_out(drq_o), .drq_oe,
        .dack_active(dack_o), .tc_active(tc_o), .rate_select, .config_control,
        .fifo_wr_stb(fws_o), .fifo_wr_data(fwd_o), .fifo_rd_stb(frs_o)
    );

    fsr_host_model host (.sys_clk, .base_addr, .host_data_oe, .host_req);

    initial forever #12.5 sys_clk = ~sys_clk;

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results;
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic rd(input logic [2:0] ofs, input logic [7:0] exp, input logic ok);
        logic seen;
        if (ok)
            exp_q.push_back(exp);
        host.access(1'b0, ofs, 8'h00, seen);
        chk("read answered", {7'h00, seen}, {7'h00, ok});
    endtask

    task automatic wr(input logic [2:0] ofs, input logic [7:0] d);
        logic seen;
        host.access(1'b1, ofs, d, seen);
    endtask

    task automatic dor_chk(input logic [7:0] v);
        cyc(2);
        chk("drive select", {4'h0, drive_select}, v[2] ? 8'h01 << v[1:0] : 8'h00);
        chk("motor on", {4'h0, motor_on}, {4'h0, v[7:4]});
        chk("soft reset", {7'h00, soft_reset_n}, {7'h00, v[2]});
        chk("dma enable", {7'h00, dma_pin_enable}, {7'h00, v[3]});
    endtask

    function automatic logic [7:0] pin_status_a(input logic alt, input logic sf);
        if (alt)
            return {core_in.irq, core_in.drq, sf, ~disk_in.track_zero_n,
                    ~core_in.head_side_select, ~disk_in.index_pulse_n,
                    ~disk_in.write_protect_n, ~core_in.step_inward};
        return {core_in.irq, disk_in.second_drive_present_n, core_in.step,
                disk_in.track_zero_n, core_in.head_side_select, disk_in.index_pulse_n,
                disk_in.write_protect_n, core_in.step_inward};
    endfunction

    // Each read answer is compared with the oldest note
    always @(posedge sys_clk) begin
        if (host_data_oe === 1'b1 && oe_q !== 1'b1) begin
            if (exp_q.size() == 0)
                chk("unexpected read", 8'h01, 8'h00);
            else
                chk("read data", host_data_out, exp_q.pop_front());
        end
        fifo_rds += (frs_o === 1'b1);
        fifo_wrs += (fws_o === 1'b1);
        oe_q <= host_data_oe;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        results();
    end

    initial begin
        r = $urandom(32'h5f8d);
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        base_addr <= r[15:0] & 16'hfff8;
        cyc(3);
        dor_chk(8'h00);
        rd(3'h2, 8'h00, 1'b1);
        rd(3'h1, 8'hc0, 1'b1);
        foreach (act[i]) begin
            wr(3'h2, act[i]);
            dor_chk(act[i]);
            rd(3'h2, act[i], 1'b1);
        end
        r = $urandom;
        wr(3'h4, r[7:0]);
        wr(3'h7, r[15:8]);
        wr(3'h2, 8'h18);
        dor_chk(8'h18);
        wr(3'h2, 8'h1c);
        dor_chk(8'h1c);
        chk("rate", rate_select, r[7:0]);
        chk("config", config_control, r[15:8]);
        wr(3'h5, r[23:16]);
        chk("fifo data", fwd_o, r[23:16]);
        wr(3'h2, 8'h2d);
        disk_in.read_data_n <= 1'b1;
        core_in.write_data <= 1'b1;
        core_in.write_gate_out <= 1'b1;
        cyc(3);
        core_in.write_data <= 1'b0;
        cyc(3);
        rd(3'h1, 8'hfe, 1'b1);
        disk_in.read_data_n <= 1'b0;
        cyc(3);
        disk_in.read_data_n <= 1'b1;
        cyc(3);
        rd(3'h1, 8'hf6, 1'b1);
        for (int i = 0; i < 4; i++) begin
            r = $urandom;
            disk_in <= {r[6:3], disk_in.read_data_n, r[1:0]};
            core_in <= (r[14:8] & 7'h33) | (core_in & 7'h0c);
            ms_in <= r[23:16];
            ff_in <= r[31:24];
            di_in <= ~r[7:0];
            cyc(3);
            rd(3'h0, pin_status_a(1'b0, 1'b0), 1'b1);
            chk("irq drq", {6'h00, irq_o, drq_o}, {6'h00, core_in.irq, core_in.drq});
            chk("dack tc", {6'h00, dack_o, tc_o}, {6'h00, ~disk_in.dack_n, disk_in.tc});
            rd(3'h4, ms_in, 1'b1);
            rd(3'h5, ff_in, 1'b1);
            rd(3'h7, di_in, 1'b1);
            rd(3'h6, 8'h00, 1'b0);
        end
        mode <= FSR_ALTERNATE;
        rd(3'h7, di_in, 1'b1);
        rd(3'h1, {disk_in.second_drive_present_n, 7'h23}, 1'b1);
        core_in.write_gate_out <= 1'b0;
        disk_in.read_data_n <= 1'b0;
        core_in.write_data <= 1'b1;
        cyc(3);
        core_in.write_gate_out <= 1'b1;
        disk_in.read_data_n <= 1'b1;
        core_in.write_data <= 1'b0;
        cyc(3);
        rd(3'h1, {disk_in.second_drive_present_n, 7'h3f}, 1'b1);
        rd(3'h7, di_in, 1'b1);
        rd(3'h1, {disk_in.second_drive_present_n, 7'h23}, 1'b1);
        core_in.step <= 1'b1;
        cyc(2);
        core_in.step <= 1'b0;
        cyc(2);
        rd(3'h0, pin_status_a(1'b1, 1'b1), 1'b1);
        rd(3'h7, di_in, 1'b1);
        rd(3'h0, pin_status_a(1'b1, 1'b0), 1'b1);
        wr(3'h2, 8'h21);
        cyc(2);
        chk("drq oe", {7'h00, drq_oe}, 8'h00);
        chk("irq oe", {7'h00, disk_irq_oe}, 8'h00);
        chk("dack tc gated", {6'h00, dack_o, tc_o}, 8'h00);
        mode <= FSR_EXTENDED;
        cyc(3);
        chk("drq oe", {7'h00, drq_oe}, 8'h01);
        chk("irq oe", {7'h00, disk_irq_oe}, 8'h01);
        mode <= FSR_LEGACY;
        rd(3'h0, 8'h00, 1'b0);
        rd(3'h1, 8'h00, 1'b0);
        mode <= FSR_EXTENDED;
        config_mode <= 1'b1;
        rd(3'h0, 8'h00, 1'b0);
        rd(3'h1, 8'h00, 1'b0);
        chk("pending reads", 8'(exp_q.size()), 8'h00);
        chk("fifo strobes", {fifo_rds[3:0], fifo_wrs[3:0]}, 8'h41);
        results();
    end
endmodule
